//--- cit_counter.sv
// Counter input timing core: edge counting, pulse-width and pulse capture.
`timescale 1ns/100ps
`default_nettype none

module cit_counter
	import cit_pkg::*;
#(
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	input  wire logic                  arm,
	input  wire logic                  disarm,
	input  wire logic [2:0]            mode,
	input  wire logic                  src_falling,
	input  wire logic                  gate_active_low,
	input  wire logic                  pause_en,
	input  wire logic [1:0]            dir_sel,
	input  wire logic                  sclk_falling,
	input  wire logic [3:0]            sclk_sel,
	input  wire logic [SCLK_SRC_N-1:0] sclk_src,
	input  wire logic                  src_in,
	input  wire logic                  gate_in,
	input  wire logic                  dir_in,
	input  wire logic                  clr_err,
	output logic [CNT_W-1:0]           count,
	output logic                       armed,
	output logic                       done,
	output logic                       overrun_err,
	output logic                       overflow_err,
	output logic [CNT_W-1:0]           strm_data,
	output logic                       strm_level,
	output logic                       strm_valid,
	input  wire logic                  strm_ready
);

	localparam int unsigned AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Behaviour notes
	// ----------------------------------------------------------------
	// Every pin passes two flops and, except Dir, then an edge detector, so an event on
	// a pin is acted on three clock edges after it changes. Source pulses
	// shorter than one clock period may therefore be lost; the measured
	// signals are expected to be much slower than the clock.
	//
	// The count is a plain register, so reading it never stalls or resets
	// the measurement. Edge modes step by one in either direction and wrap
	// silently at the ends of the range.
	//
	// Pulse-width modes count up only. The count restarts at the first leading Gate
	// edge after arming and then at each trailing one (every Gate edge in pulse modes),
	// and a Source edge that falls in the same cycle as a Gate edge is given to
	// neither interval, which keeps the halves apart.
	//
	// Sample-clocked pulse modes push the last completed active width on
	// every sample edge, so a slow Gate yields repeated words. The overrun
	// flag is only judged from the second sample edge on, since there is
	// no earlier interval to miss.
	//
	// The FIFO drops words when full rather than stalling the count: the
	// measurement must not be disturbed by a slow host. The sticky
	// overflow flag tells software that the stream has a gap.
	//
	// Configuration ports are read live; changing them while armed gives
	// undefined results, so software sets them up before arming.

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]       rst_sync;
		logic [1:0]       src_s;
		logic [1:0]       gate_s;
		logic [1:0]       dir_s;
		logic [1:0]       sclk_s;
		logic             src_prev;
		logic             gate_prev;
		logic             sclk_prev;
		cit_state_e       st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] last_act;
		logic [CNT_W-1:0] last_inact;
		logic             have_pulse;
		logic             sampled_once;
		logic             phase_act;
		logic             overrun;
		logic             overflow;
		logic [AW:0]      wr_ptr;
		logic [AW:0]      rd_ptr;
		logic [CNT_W-1:0] out_data;
		logic             out_valid;
	} cit_state_s;

	cit_state_s q, d;
	logic [CNT_W-1:0] fifo_mem [DEPTH];

	// Reset release through two flops; the core uses the synchronised copy.
	logic [1:0] rst_pipe_q;
	logic       rst_n_sync;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end

	assign rst_n_sync = rst_pipe_q[1];

	// Selects the external sample clock; no divider exists here.
	function automatic logic pick_sclk(input logic [SCLK_SRC_N-1:0] srcs,
			input logic [3:0] sel);
		pick_sclk = (sel < 4'(SCLK_SRC_N)) ? srcs[sel] : 1'b0;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic             src_edge;
	logic             gate_act;
	logic             gate_lead;
	logic             gate_trail;
	logic             sclk_edge;
	logic             push;
	logic [CNT_W-1:0] push_data;
	logic             fifo_full;
	logic             fifo_empty;
	logic             pop;
	logic             is_edge;
	logic             is_pulse;
	logic             is_single;
	logic             is_impl;
	logic             is_sclk;
	logic             cnt_en;
	logic [CNT_W-1:0] cnt_step;
	logic             ovr_set;

	always_comb begin
		d = q;
		d.rst_sync = '0;
		d.src_s  = {q.src_s[0], src_in};
		d.gate_s = {q.gate_s[0], gate_in};
		d.dir_s  = {q.dir_s[0], dir_in};
		d.sclk_s = {q.sclk_s[0], pick_sclk(sclk_src, sclk_sel)};
		d.src_prev  = q.src_s[1];
		d.gate_prev = q.gate_s[1] ^ gate_active_low;
		d.sclk_prev = q.sclk_s[1];

		// Edge events from the second synchroniser stage onward only.
		src_edge = src_falling ? (q.src_prev & ~q.src_s[1])
			: (~q.src_prev & q.src_s[1]);
		gate_act   = q.gate_s[1] ^ gate_active_low;
		gate_lead  = gate_act & ~q.gate_prev;
		gate_trail = ~gate_act & q.gate_prev;
		sclk_edge  = sclk_falling ? (q.sclk_prev & ~q.sclk_s[1])
			: (~q.sclk_prev & q.sclk_s[1]);

		is_edge   = (mode == MODE_EDGE_DEMAND) || (mode == MODE_EDGE_SCLK);
		is_pulse  = (mode == MODE_PULSE_SINGLE) || (mode == MODE_PULSE_IMPL)
			|| (mode == MODE_PULSE_SCLK);
		is_single = (mode == MODE_PW_SINGLE) || (mode == MODE_PULSE_SINGLE);
		is_impl   = (mode == MODE_PW_IMPL) || (mode == MODE_PULSE_IMPL);
		// Edge counting has only sample-clocked buffering.
		is_sclk   = (mode == MODE_EDGE_SCLK) || (mode == MODE_PW_SCLK)
			|| (mode == MODE_PULSE_SCLK);

		// Count direction for edge counting; measurements always count up.
		if (is_edge && dir_sel == DIR_DOWN) begin
			cnt_step = '1;
		end else if (is_edge && dir_sel == DIR_EXT && !q.dir_s[1]) begin
			cnt_step = '1;
		end else begin
			cnt_step = CNT_W'(1);
		end

		cnt_en    = 1'b0;
		ovr_set   = 1'b0;
		push      = 1'b0;
		push_data = q.cnt;

		case (q.st)
			CIT_IDLE: begin
				if (arm) begin
					d.cnt = CNT_RST;
					d.have_pulse = 1'b0;
					d.sampled_once = 1'b0;
					d.overrun = 1'b0;
					// Partial pulse at arm is thrown away.
					d.st = is_edge ? CIT_RUN : CIT_WAIT;
				end
			end
			CIT_WAIT: begin
				if (gate_lead) begin
					d.st = CIT_RUN;
					d.phase_act = 1'b1;
					d.cnt = CNT_RST;
				end
			end
			CIT_RUN: begin
				if (is_edge) begin
					// Pause gate blocks Source edges while active.
					cnt_en = src_edge && !(pause_en && gate_act);
					if (is_sclk && sclk_edge) begin
						push = 1'b1;
					end
				end else begin
					cnt_en = src_edge && (is_pulse || gate_act);
					if (gate_trail || (is_pulse && gate_lead)) begin
						push_data = q.cnt;
						d.cnt = CNT_RST;
						d.phase_act = gate_lead;
						if (gate_trail) begin
							d.last_act = q.cnt;
						end else begin
							d.last_inact = q.cnt;
						end
						// A pulse completes at trailing edge, or next lead in
						// pulse mode where the inactive half is also wanted.
						if (gate_trail ^ is_pulse) begin
							d.have_pulse = 1'b1;
						end
						if (is_impl) begin
							push = 1'b1;
						end else if (is_single) begin
							push = 1'b1;
							if (!is_pulse || gate_lead) begin
								d.st = CIT_DONE;
							end
						end
					end
					if (is_sclk && sclk_edge) begin
						// Report last completed width; note missing pulses.
						push = 1'b1;
						push_data = q.last_act;
						if (!q.have_pulse && q.sampled_once) begin
							d.overrun = 1'b1;
							ovr_set   = 1'b1;
						end
						d.have_pulse = 1'b0;
						d.sampled_once = 1'b1;
					end
				end
			end
			CIT_DONE: begin
				cnt_en = 1'b0;
			end
			default: d.st = CIT_IDLE;
		endcase

		if (cnt_en) begin
			d.cnt = (gate_trail || gate_lead) && !is_edge
				? d.cnt : q.cnt + cnt_step;
		end
		if (disarm) begin
			d.st = CIT_IDLE;
		end

		// FIFO write with drop on full.
		fifo_full  = (q.wr_ptr[AW] != q.rd_ptr[AW])
			&& (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
		fifo_empty = q.wr_ptr == q.rd_ptr;
		if (push && !fifo_full) begin
			d.wr_ptr = q.wr_ptr + 1'b1;
		end else if (push) begin
			d.overflow = 1'b1;
		end

		// Output register refilled from the FIFO as the sink drains it.
		pop = !fifo_empty && (!q.out_valid || strm_ready);
		if (pop) begin
			d.out_data  = fifo_mem[q.rd_ptr[AW-1:0]];
			d.out_valid = 1'b1;
			d.rd_ptr    = q.rd_ptr + 1'b1;
		end else if (strm_ready) begin
			d.out_valid = 1'b0;
		end

		// Set wins over a clear arriving in the same cycle.
		if (clr_err) begin
			d.overflow = push && fifo_full;
			d.overrun = ovr_set;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// FIFO storage array, written in the same push cycle.
	always_ff @(posedge ref_clk) begin
		if (push && !fifo_full) begin
			fifo_mem[q.wr_ptr[AW-1:0]] <= push_data;
		end
	end

	assign count        = q.cnt;
	assign armed        = (q.st == CIT_WAIT) || (q.st == CIT_RUN);
	assign done         = q.st == CIT_DONE;
	assign overrun_err  = q.overrun;
	assign overflow_err = q.overflow;
	assign strm_data    = q.out_data;
	assign strm_valid   = q.out_valid;
	assign strm_level   = ~fifo_empty;

endmodule : cit_counter

`default_nettype wire

//--- cit_pkg.sv
// Package of constants and types for the counter input timing block.
package cit_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W    = 32;
	localparam int unsigned SCLK_SEL_W = 4;
	localparam logic [31:0] CNT_RST  = 32'h0000_0000;

	// Sample clock sources, selected by the sclk_sel port.
	localparam logic [3:0] SCLK_AI_SAMPLE = 4'h0;
	localparam logic [3:0] SCLK_AI_START  = 4'h1;
	localparam logic [3:0] SCLK_AI_REF    = 4'h2;
	localparam logic [3:0] SCLK_AO_SAMPLE = 4'h3;
	localparam logic [3:0] SCLK_DI_SAMPLE = 4'h4;
	localparam logic [3:0] SCLK_DI_START  = 4'h5;
	localparam logic [3:0] SCLK_DO_SAMPLE = 4'h6;
	localparam logic [3:0] SCLK_CTR_OUT   = 4'h7;
	localparam logic [3:0] SCLK_FREQ_OUT  = 4'h8;
	localparam logic [3:0] SCLK_PFT       = 4'h9;
	localparam logic [3:0] SCLK_CHG_DET   = 4'hA;
	localparam logic [3:0] SCLK_ANA_CMP   = 4'hB;
	localparam int unsigned SCLK_SRC_N    = 12;

	// Measurement modes.
	localparam logic [2:0] MODE_EDGE_DEMAND = 3'h0;
	localparam logic [2:0] MODE_EDGE_SCLK   = 3'h1;
	localparam logic [2:0] MODE_PW_SINGLE   = 3'h2;
	localparam logic [2:0] MODE_PW_IMPL     = 3'h3;
	localparam logic [2:0] MODE_PW_SCLK     = 3'h4;
	localparam logic [2:0] MODE_PULSE_SINGLE = 3'h5;
	localparam logic [2:0] MODE_PULSE_IMPL  = 3'h6;
	localparam logic [2:0] MODE_PULSE_SCLK  = 3'h7;

	// Count direction selection.
	localparam logic [1:0] DIR_UP   = 2'h0;
	localparam logic [1:0] DIR_DOWN = 2'h1;
	localparam logic [1:0] DIR_EXT  = 2'h2;

	typedef enum logic [1:0] {
		CIT_IDLE,
		CIT_WAIT,
		CIT_RUN,
		CIT_DONE
	} cit_state_e;

endpackage : cit_pkg

//--- cit_counter_sva.sv
// Assertion checker for the counter input timing core.
`timescale 1ns/100ps
`default_nettype none
module cit_counter_chk
	import cit_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             rstn,
	input wire logic             arm,
	input wire logic             disarm,
	input wire logic [2:0]       mode,
	input wire logic             gate_active_low,
	input wire logic             pause_en,
	input wire logic [1:0]       dir_sel,
	input wire logic             gate_in,
	input wire logic             clr_err,
	input wire logic [CNT_W-1:0] count,
	input wire logic             armed,
	input wire logic             done,
	input wire logic             overrun_err,
	input wire logic             overflow_err,
	input wire logic [CNT_W-1:0] strm_data,
	input wire logic             strm_valid,
	input wire logic             strm_ready
);
	logic [2:0] up_q;
	// Age since reset release; the core sees reset two edges late.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	wire logic live = (up_q == 3'h7);
	wire logic ed   = (mode <= MODE_EDGE_SCLK);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	AST_HOLD: assert property (strm_valid && !strm_ready |=> strm_valid && $stable(strm_data)) else $error("stream word dropped");
	AST_OVR: assert property (live && overrun_err && !clr_err |=> overrun_err) else $error("overrun flag lost");
	AST_OVF: assert property (live && overflow_err && !clr_err |=> overflow_err) else $error("overflow flag lost");
	AST_ARM: assert property (live && ed && arm && !disarm && !armed |=> armed) else $error("arm not taken");
	AST_DISARM: assert property (disarm |=> !armed) else $error("disarm not taken");
	AST_IDLE: assert property (live && !armed && !arm |=> $stable(count)) else $error("count moved while idle");
	AST_PAUSE: assert property ((armed && ed && pause_en && gate_in != gate_active_low)[*6] |=> $stable(count)) else $error("count moved in pause");
	AST_UP: assert property (live && armed && ed && dir_sel == DIR_UP && !disarm |=> count - $past(count) <= 32'h1) else $error("bad up step");
	AST_DOWN: assert property (live && armed && ed && dir_sel == DIR_DOWN && !disarm |=> $past(count) - count <= 32'h1) else $error("bad down step");
	COV_PUSH: cover property (strm_valid && strm_ready);
	COV_OVR: cover property ($rose(overrun_err));
	COV_DONE: cover property ($rose(done));
endmodule // cit_counter_chk
bind cit_counter cit_counter_chk chk (.*);
`default_nettype wire

//--- cit_ext.sv
// Model of the measured pins, sample clocks and the host stream sink.
`timescale 1ns/100ps
`default_nettype none
module cit_ext
	import cit_pkg::*;
(
	input  wire logic            ref_clk,
	output logic                 src_in,
	output logic                 gate_in,
	output logic                 dir_in,
	output logic [SCLK_SRC_N-1:0] sclk_src,
	output logic                 strm_ready
);
	integer seed = 32'h4089;
	// Gate polarity applied by the gate task, so callers speak in levels.
	logic inv = 1'b0;
	initial begin
		{src_in, gate_in, dir_in, strm_ready} = 4'h0;
		sclk_src = '0;
	end
	// Host stalls about one cycle in four, so stand-still is exercised.
	always @(negedge ref_clk) strm_ready <= (($random(seed) & 3) != 0);
	// Slow pulses give the pin synchronisers room on both levels.
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(negedge ref_clk);
			src_in <= 1'b1;
			repeat (4) @(negedge ref_clk);
			src_in <= 1'b0;
		end
	endtask
	task automatic gate(input logic v);
		@(negedge ref_clk) gate_in <= v ^ inv;
		repeat (6) @(negedge ref_clk);
	endtask
	// One full sample clock pulse on an external source only.
	task automatic sclk(input int s);
		repeat (4) @(negedge ref_clk);
		sclk_src[s] <= 1'b1;
		repeat (4) @(negedge ref_clk);
		sclk_src[s] <= 1'b0;
		repeat (8) @(negedge ref_clk);
	endtask
endmodule // cit_ext
`default_nettype wire

//--- counter_input_timing_test.sv
// Self-checking testbench of the counter input timing core.
`timescale 1ns/100ps
`default_nettype none
module counter_input_timing_test
	import cit_pkg::*;
;
	logic ref_clk, rstn, arm, disarm, src_falling, gate_active_low, pause_en;
	logic sclk_falling, clr_err, armed, done, overrun_err, overflow_err;
	logic strm_level, strm_valid, src_in, gate_in, dir_in, strm_ready;
	logic [2:0] mode;
	logic [1:0] dir_sel;
	logic [3:0] sclk_sel;
	logic [SCLK_SRC_N-1:0] sclk_src;
	logic [31:0] count, strm_data, n;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int check_count = 0;
	cit_counter #(.DEPTH(4)) dut (.ref_clk(ref_clk), .rstn(rstn), .arm(arm),
		.disarm(disarm), .mode(mode), .src_falling(src_falling),
		.gate_active_low(gate_active_low), .pause_en(pause_en),
		.dir_sel(dir_sel), .sclk_falling(sclk_falling), .sclk_sel(sclk_sel),
		.sclk_src(sclk_src), .src_in(src_in), .gate_in(gate_in),
		.dir_in(dir_in), .clr_err(clr_err), .count(count), .armed(armed),
		.done(done), .overrun_err(overrun_err), .overflow_err(overflow_err),
		.strm_data(strm_data), .strm_level(strm_level),
		.strm_valid(strm_valid), .strm_ready(strm_ready));
	cit_ext ext (.ref_clk(ref_clk), .src_in(src_in), .gate_in(gate_in),
		.dir_in(dir_in), .sclk_src(sclk_src), .strm_ready(strm_ready));
	always #25 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Each accepted stream word is matched against the oldest note.
	always @(posedge ref_clk) begin
		if (strm_valid === 1'b1 && strm_ready === 1'b1) begin
			if (exp_q.size() == 0) chk("extra_word", 32'h0, 32'h1);
			else chk("strm_data", exp_q.pop_front(), strm_data);
		end
	end
	task automatic start(input logic [2:0] m);
		@(negedge ref_clk);
		mode = m;
		arm = 1'b1;
		@(negedge ref_clk);
		arm = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("armed", 32'h1, {31'h0, armed});
	endtask
	// Drain under a bound, then return to idle for the next setup.
	task automatic stop(input string nm);
		for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(negedge ref_clk);
		if (exp_q.size() != 0) chk("drain", 32'h0, 32'(exp_q.size()));
		chk("level", 32'h0, {31'h0, strm_level});
		chk("overflow", 32'h0, {31'h0, overflow_err});
		disarm = 1'b1;
		@(negedge ref_clk);
		disarm = 1'b0;
		$display("test %s done", nm);
	endtask
	initial begin
		#2000000;
		chk("timeout", 32'h0, 32'h1);
		summarize();
	end
	initial begin
		{ref_clk, rstn, arm, disarm, src_falling, gate_active_low} = 6'h0;
		{pause_en, sclk_falling, clr_err} = 3'h0;
		mode = MODE_EDGE_SCLK;
		dir_sel = DIR_UP;
		sclk_sel = 4'h0;
		repeat (3) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int s = 0; s < SCLK_SRC_N; s++) begin
			n = 32'h1 + 32'($random(ext.seed) & 3);
			sclk_sel = 4'(s);
			sclk_falling = s[0];
			src_falling = s[1];
			start(MODE_EDGE_SCLK);
			ext.pulses(n);
			exp_q.push_back(n);
			ext.sclk(s);
			ext.pulses(1);
			exp_q.push_back(n + 32'h1);
			ext.sclk(s);
			chk("count", n + 32'h1, count);
			stop("sample_clock");
		end
		for (int d = 0; d < 4; d++) begin
			dir_sel = (d == 3) ? DIR_EXT : 2'(d);
			ext.dir_in = d[0];
			src_falling = d[1];
			start(MODE_EDGE_DEMAND);
			ext.pulses(3);
			repeat (4) @(negedge ref_clk);
			chk("count", (d == 1 || d == 2) ? -32'h3 : 32'h3, count);
			stop("direction");
		end
		{dir_sel, pause_en, gate_active_low} = 4'h3;
		start(MODE_EDGE_DEMAND);
		ext.pulses(3);
		ext.gate(1'b1);
		ext.pulses(2);
		repeat (4) @(negedge ref_clk);
		chk("count", 32'h2, count);
		stop("pause");
		pause_en = 1'b0;
		gate_active_low = 1'($random(ext.seed));
		src_falling = 1'($random(ext.seed));
		ext.inv = gate_active_low;
		ext.gate(1'b1);
		start(MODE_PW_IMPL);
		ext.pulses(2);
		ext.gate(1'b0);
		ext.gate(1'b1);
		ext.pulses(4);
		exp_q.push_back(32'h4);
		ext.gate(1'b0);
		ext.gate(1'b1);
		ext.pulses(2);
		exp_q.push_back(32'h2);
		ext.gate(1'b0);
		stop("pw_implicit");
		start(MODE_PW_SINGLE);
		ext.gate(1'b1);
		ext.pulses(3);
		exp_q.push_back(32'h3);
		ext.gate(1'b0);
		ext.gate(1'b1);
		ext.pulses(2);
		ext.gate(1'b0);
		chk("done", 32'h1, {31'h0, done});
		stop("pw_single");
		start(MODE_PW_SCLK);
		ext.gate(1'b1);
		ext.pulses(5);
		ext.gate(1'b0);
		exp_q.push_back(32'h5);
		ext.sclk(sclk_sel);
		exp_q.push_back(32'h5);
		ext.sclk(sclk_sel);
		chk("overrun", 32'h1, {31'h0, overrun_err});
		clr_err = 1'b1;
		@(negedge ref_clk);
		clr_err = 1'b0;
		@(negedge ref_clk);
		chk("overrun", 32'h0, {31'h0, overrun_err});
		stop("pw_sample_clock");
		start(MODE_PULSE_IMPL);
		ext.gate(1'b1);
		ext.pulses(3);
		exp_q.push_back(32'h3);
		ext.gate(1'b0);
		ext.pulses(2);
		exp_q.push_back(32'h2);
		ext.gate(1'b1);
		stop("pulse_implicit");
		start(MODE_PULSE_SINGLE);
		ext.gate(1'b0);
		ext.gate(1'b1);
		ext.pulses(2);
		exp_q.push_back(32'h2);
		ext.gate(1'b0);
		ext.pulses(1);
		exp_q.push_back(32'h1);
		ext.gate(1'b1);
		chk("done", 32'h1, {31'h0, done});
		stop("pulse_single");
		summarize();
	end
endmodule // counter_input_timing_test
`default_nettype wire
